// >>> common/banked_io_map.vh
// Purpose: address map and field layout of the banked digital I/O block
// Assumes: byte-wide host I/O bus, 16-bit I/O addresses
// Notes: definitions only
`ifndef BANKED_IO_MAP_VH
`define BANKED_IO_MAP_VH

`define ADDR_W 16
`define IN_BANK_B_LOW 16'h4040
`define IN_BANK_B_HIGH 16'h4041
`define IN_BANK_A_HIGH 16'h4042
`define IN_BANK_A_LOW 16'h4043
`define OUT_BANK_B_LOW 16'h4100
`define OUT_BANK_B_HIGH 16'h4108
`define OUT_BANK_A_LOW 16'h4110
`define OUT_BANK_A_HIGH 16'h4118
`define SEL_MSB 3
`define SEL_LSB 1
`define STATE_BIT 0
`define OUT_RESET 8'h00
`define READ_IDLE 8'h00

`endif

// >>> rtl/input_group_mux.v
// Purpose: selects one group of eight input levels for a port read
// Assumes: channel vector indexed by physical channel number
// Notes: combinational; decode of unmapped address returns zero
`timescale 1ns/1ps
`default_nettype none
`include "banked_io_map.vh"
module input_group_mux (
  // address and levels
  input wire [`ADDR_W-1:0] addr,
  input wire [31:0] levels,
  // result
  output reg hit,
  output reg [7:0] data
);
  always @* begin
    hit = 1'b1;
    case (addr)
      `IN_BANK_B_LOW: data = levels[7:0];
      `IN_BANK_B_HIGH: data = levels[15:8];
      `IN_BANK_A_HIGH: data = levels[31:24];
      `IN_BANK_A_LOW: data = levels[23:16];
      default: begin
        hit = 1'b0;
        data = `READ_IDLE;
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> rtl/output_group.v
// Purpose: eight output latches written one at a time by index
// Assumes: write strobe one cycle wide, synchronous reset
// Notes: one flip-flop per output, generate loop
`timescale 1ns/1ps
`default_nettype none
`include "banked_io_map.vh"
module output_group (
  // clock and reset
  input wire mclk,
  input wire reset,
  // write request
  input wire wrEn,
  input wire [2:0] index,
  input wire state,
  // driver states
  output wire [7:0] drive
);
  reg [7:0] drive_reg;
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_out
      always @(posedge mclk) begin
        if (reset) begin
          drive_reg[i] <= 1'b0;
        end else if (wrEn && index == i[2:0]) begin
          drive_reg[i] <= state;
        end
      end
    end
  endgenerate
  assign drive = drive_reg;
endmodule
`default_nettype wire

// >>> rtl/banked_digital_io_ports.v
// Purpose: host-addressed digital I/O, 32 channels in two banks
// Assumes: host bus strobes one cycle wide, synchronous to mclk
// Notes: reads are registered, answer one cycle after the strobe
// Notes on behaviour
// - input bit equals pin level
// - channels 0-15 second bank, 16-31 first
// - four read-only input port addresses
// - bit n is nth channel of group
// - four write-only output group addresses
// - data bits 3..1 select the output
// - data bit 0 is new state
// - data bits 7..4 ignored
// - first bank inputs, second bank outputs
`timescale 1ns/1ps
`default_nettype none
`include "banked_io_map.vh"
module banked_digital_io_ports (
  // clock and reset
  input wire mclk,
  input wire reset,
  // host I/O bus
  input wire [`ADDR_W-1:0] ioAddr,
  input wire ioRd,
  input wire ioWr,
  input wire [7:0] ioWrData,
  output reg [7:0] ioRdData_reg,
  output reg ioRdValid_reg,
  // channel pins
  input wire [15:0] first_bank_channels,
  output wire [15:0] second_bank_channels
);
  // geometry
  localparam GROUPS = 4;
  localparam BANK_W = 16;
  localparam CHANNELS = 32;

  // physical channel views
  wire [CHANNELS-1:0] inLevels;
  wire [CHANNELS-1:0] outStates;
  wire [BANK_W-1:0] secondBankIn;
  // read side
  wire [7:0] rdMux;
  wire rdHit;
  reg [7:0] rdData_next;
  reg rdValid_next;
  // write side
  reg [GROUPS-1:0] grpWr;
  wire [2:0] selIndex;
  wire selState;

  // second bank pins only drive, so they read back as zero
  assign secondBankIn = 16'h0000;

  // physical numbering: second bank low, first bank high
  genvar c;
  generate
    for (c = 0; c < BANK_W; c = c + 1) begin : g_chan
      assign inLevels[c] = secondBankIn[c];
      assign inLevels[BANK_W+c] = first_bank_channels[c];
      assign second_bank_channels[c] = outStates[c];
    end
  endgenerate

  input_group_mux u_mux (
    .addr(ioAddr),
    .levels(inLevels),
    .hit(rdHit),
    .data(rdMux)
  );

  // read answer: pin level as is, nth channel at bit n
  always @* begin
    rdData_next = `READ_IDLE;
    rdValid_next = 1'b0;
    if (ioRd) begin
      rdValid_next = 1'b1;
      if (rdHit) begin
        rdData_next = rdMux;
      end else begin
        rdData_next = `READ_IDLE;
      end
    end
  end

  // answer stands one cycle, then returns to idle
  always @(posedge mclk) begin
    if (reset) begin
      ioRdData_reg <= `READ_IDLE;
      ioRdValid_reg <= 1'b0;
    end else begin
      ioRdValid_reg <= rdValid_next;
      ioRdData_reg <= rdData_next;
    end
  end

  // write decode; unmapped writes touch nothing
  always @* begin
    grpWr = 4'h0;
    if (ioWr) begin
      case (ioAddr)
        `OUT_BANK_B_LOW: begin
          grpWr[0] = 1'b1;
        end
        `OUT_BANK_B_HIGH: begin
          grpWr[1] = 1'b1;
        end
        `OUT_BANK_A_LOW: begin
          grpWr[2] = 1'b1;
        end
        `OUT_BANK_A_HIGH: begin
          grpWr[3] = 1'b1;
        end
        default: begin
          grpWr = 4'h0;
        end
      endcase
    end
  end

  // upper data bits never reach the latches
  assign selIndex = ioWrData[`SEL_MSB:`SEL_LSB];
  assign selState = ioWrData[`STATE_BIT];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_grp
      output_group u_grp (
        .mclk(mclk),
        .reset(reset),
        .wrEn(grpWr[g]),
        .index(selIndex),
        .state(selState),
        .drive(outStates[g*8+7:g*8])
      );
    end
  endgenerate
endmodule
`default_nettype wire

// >>> test/field_pins.sv
// Purpose: pins. Assumes: mclk. Notes: lag
`timescale 1ns/1ps
`default_nettype none
module field_pins(input wire logic mclk,input wire logic [15:0] lv,
  output logic [15:0] pins);
  always @(posedge mclk) pins<=lv;
endmodule
`default_nettype wire

// >>> test/io_props.sv
// Purpose: checks. Assumes: mclk. Notes: bind
`timescale 1ns/1ps
`default_nettype none
module io_props(input wire logic mclk,reset,ioRd,ioWr,ioRdValid_reg,
  input wire logic [15:0] ioAddr,first_bank_channels,second_bank_channels,
  input wire logic [7:0] ioWrData,ioRdData_reg);
  default clocking @(posedge mclk);endclocking
  default disable iff(reset);
  property p_v;ioRd|=>ioRdValid_reg;endproperty
  a_v:assert property(p_v)else $error("v");
  property p_l;ioRd&&ioAddr==16'h4043|=>
    ioRdData_reg==$past(first_bank_channels[7:0]);endproperty
  a_l:assert property(p_l)else $error("l");
  property p_w;ioWr&&ioAddr==16'h4100|=>
    second_bank_channels[$past(ioWrData[3:1])]==$past(ioWrData[0]);endproperty
  a_w:assert property(p_w)else $error("w");
  property p_h;ioWr&&ioAddr==16'h4108|=>
    second_bank_channels[8+$past(ioWrData[3:1])]==$past(ioWrData[0]);
  endproperty
  a_h:assert property(p_h)else $error("h");
  property p_s;!(ioWr&&(ioAddr==16'h4100||ioAddr==16'h4108))|=>
    $stable(second_bank_channels);endproperty
  a_s:assert property(p_s)else $error("s");
  property p_z;!ioRd|=>!ioRdValid_reg&&ioRdData_reg==8'h00;endproperty
  a_z:assert property(p_z)else $error("z");
  property p_a;ioRd&&ioAddr==16'h4042|=>
    ioRdData_reg==$past(first_bank_channels[15:8]);endproperty
  a_a:assert property(p_a)else $error("a");
endmodule
bind banked_digital_io_ports io_props chk(.*);
`default_nettype wire

// >>> test/banked_digital_io_ports_bench.sv
// Purpose: bench. Assumes: 20 ns. Notes: seed
`timescale 1ns/1ps
`default_nettype none
`define CK(a,b) begin checks_done++;if((a)!==(b))begin n_fail++;\
$display("Error %0t bad",$time);end end
module banked_digital_io_ports_bench;
  logic mclk=0,reset=1,ioRd=0,ioWr=0,ioRdValid_reg;
  logic [15:0] ioAddr=0,lv=0,eo=0,first_bank_channels,second_bank_channels;
  logic [7:0] ioWrData=0,ioRdData_reg;
  integer seed=10060,n_fail=0,checks_done=0,t;
  initial forever #10 mclk=~mclk;
  field_pins fp(.mclk,.lv,.pins(first_bank_channels));
  banked_digital_io_ports dut(.*);
  task results;
    $display("n_fail %0d checks_done %0d",n_fail,checks_done);
    if(n_fail==0&&checks_done>0)$display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat(20)@(posedge mclk);
    #1 reset=0;
    repeat(300)begin
      t=$random(seed);
      lv=t[31:16];
      @(posedge mclk) #1 {ioWr,ioRd,ioWrData}={2'b11,t[17:10]};
      ioAddr=t[9]?{11'h208,t[4:3],3'h0}:{14'h1010,t[1:0]};
      if(t[9]&!t[4])eo[{t[3],t[13:11]}]=t[10];
      @(posedge mclk) #1 {ioRd,ioWr}=0;
      `CK(second_bank_channels,eo)
      `CK(ioRdData_reg,t[9]|!t[1]?8'h00:t[0]?lv[7:0]:lv[15:8])
      `CK(ioRdValid_reg,1'b1)
    end
    // high data bits set, index 0 on
    @(posedge mclk) #1 {ioWr,ioAddr,ioWrData}={1'b1,16'h4100,8'hF1};
    eo[0]=1'b1;
    @(posedge mclk) #1 ioWr=0;
    `CK(second_bank_channels,eo)
    `CK(ioRdValid_reg,1'b0)
    `CK(ioRdData_reg,8'h00)
    // unmapped read answers zero
    @(posedge mclk) #1 {ioRd,ioAddr}={1'b1,16'h4044};
    @(posedge mclk) #1 ioRd=0;
    `CK(ioRdData_reg,8'h00)
    // reset in mid-run clears every driver
    reset=1;
    repeat(2)@(posedge mclk);
    #1 reset=0;
    eo=0;
    `CK(second_bank_channels,eo)
    results;
  end
endmodule
`default_nettype wire
